/* lic_line_ctrl.sv */
// Line interface control: registers, CMI coder and decoder, jitter pacing
`timescale 1ns/10ps
`include "lic_line_cfg.svh"
module lic_line_ctrl #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [7:0] RD_DATA,
    input wire logic CMI_ENABLE,
    input wire logic LINE_TEST_SELECT,
    input wire logic EXTERNAL_POWER_DOWN_PIN,
    input wire logic E1_MODE,
    input wire logic ZERO_SUB_EN,
    input wire logic JITTER_TRIP_CLEAR,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic TX_LINE_POS,
    output logic TX_LINE_POS_OE_N,
    output logic TX_LINE_NEG,
    output logic TX_LINE_NEG_OE_N,
    input wire logic RX_LINE_POS,
    output logic RX_DATA,
    output logic RX_VALID,
    output logic RX_RECOVERED_CLK,
    output logic JITTER_LIMIT_TRIP,
    output logic JITTER_ATTEN_ACTIVE,
    output logic JITTER_ATTEN_TX_SIDE,
    output logic [1:0] EQ_GAIN_LIMIT,
    output logic [2:0] LINE_BUILD_OUT,
    output logic HIGH_RETURN_LOSS,
    output logic [7:0] PULSE_SHAPE_ONE,
    output logic [7:0] PULSE_SHAPE_TWO
);
    generate
        if (FIFO_DEPTH * 8 < 128 || FIFO_DEPTH * 8 > 248)
        begin : g_bad_depth
            $error("lic_line_ctrl: FIFO must hold 128 to 248 bits");
        end
    endgenerate

    lic_pkg::lic_top_state_t s;
    lic_pkg::lic_top_state_t next_s;

    lic_fifo_if #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) fif ();

    lic_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .port(fif)
    );

    logic transmit_power_down_n;
    logic jitter_atten_disable;
    logic jitter_buffer_depth_sel;
    logic jitter_atten_side_sel;
    logic equalizer_gain_limit;
    logic [2:0] build_out;
    logic tx_enable;
    logic ja_on_tx;
    logic [7:0] depth_bits;
    logic [7:0] trip_bits;
    logic [7:0] fill_bits;
    logic boundary;
    logic first_half;
    logic [4:0] mid;
    logic new_bit;
    logic new_viol;
    logic pop;
    logic rx_fall;

    assign transmit_power_down_n = s.ctrl_one[`LIC_BIT_TX_POWER];
    assign jitter_atten_disable = s.ctrl_one[`LIC_BIT_JA_DISABLE];
    assign jitter_buffer_depth_sel = s.ctrl_one[`LIC_BIT_JA_DEPTH];
    assign jitter_atten_side_sel = s.ctrl_one[`LIC_BIT_JA_SIDE];
    assign equalizer_gain_limit = s.ctrl_one[`LIC_BIT_EQ_LIMIT];
    assign build_out = s.ctrl_one[`LIC_LBO_MSB:`LIC_LBO_LSB];

    // Pin override only counts when line test select is set
    assign tx_enable = transmit_power_down_n
        && !(LINE_TEST_SELECT && EXTERNAL_POWER_DOWN_PIN); // RULE_07 RULE_08

    // Pacing of the transmit bit rate only applies with the attenuator on the transmit side
    assign ja_on_tx = !jitter_atten_disable && jitter_atten_side_sel; // RULE_09 RULE_11
    assign depth_bits = jitter_buffer_depth_sel ? `LIC_JA_DEPTH_SHALLOW
        : `LIC_JA_DEPTH_DEEP; // RULE_10
    assign trip_bits = jitter_buffer_depth_sel ? `LIC_JA_TRIP_SHALLOW
        : `LIC_JA_TRIP_DEEP; // RULE_17
    assign fill_bits = {fif.count, 3'h0}
        + ((s.tx_state == lic_pkg::LIC_TX_SHIFT) ? {5'h00, s.bits_left} : 8'h00);

    // Source is held off once the selected depth is reached, so the shallow
    // buffer really limits delay instead of just moving the trip point
    assign fif.in_data = TX_DATA;
    assign fif.in_valid = TX_VALID && (fill_bits < depth_bits); // RULE_10
    assign TX_READY = fif.in_ready && (fill_bits < depth_bits);

    assign boundary = (s.cnt == s.div - 5'h01);
    assign mid = {1'b0, s.div[4:1]};
    assign first_half = (s.cnt < mid);
    assign pop = boundary && (s.tx_state == lic_pkg::LIC_TX_IDLE) && fif.out_valid;
    assign fif.out_ready = pop;
    assign rx_fall = s.rx_prev && !RX_LINE_POS;

    always_comb
    begin
        new_bit = 1'b0;
        if (s.tx_state == lic_pkg::LIC_TX_SHIFT)
        begin
            new_bit = s.shreg[0];
        end
        else if (fif.out_valid)
        begin
            new_bit = fif.out_data[0];
        end
        // Fourth zero in a row becomes a violation mark
        new_viol = ZERO_SUB_EN && !new_bit && (s.zero_run == 2'h3); // RULE_05
    end

    always_comb
    begin
        next_s = s;

        // Register port; unmapped reads return zero
        if (WR_EN)
        begin
            unique case (ADDR)
                `LIC_ADDR_CTRL_ONE: next_s.ctrl_one = WR_DATA;
                `LIC_ADDR_PSA_ONE: next_s.psa_one = WR_DATA;
                `LIC_ADDR_PSA_TWO: next_s.psa_two = WR_DATA;
                default: next_s.ctrl_one = s.ctrl_one;
            endcase
        end
        if (RD_EN)
        begin
            unique case (ADDR)
                `LIC_ADDR_CTRL_ONE: next_s.rd_data = s.ctrl_one;
                `LIC_ADDR_PSA_ONE: next_s.rd_data = s.psa_one;
                `LIC_ADDR_PSA_TWO: next_s.rd_data = s.psa_two;
                default: next_s.rd_data = 8'h00;
            endcase
        end

        // Bit period counter and serializer
        next_s.cnt = s.cnt + 5'h01;
        if (boundary)
        begin
            next_s.cnt = 5'h00;
            next_s.div = `LIC_DIV_NORMAL; // RULE_17
            if (ja_on_tx && fill_bits >= trip_bits)
            begin
                next_s.div = `LIC_DIV_FAST; // RULE_17
            end
            else if (ja_on_tx && fif.out_valid && fill_bits <= `LIC_JA_LOW_MARK)
            begin
                next_s.div = `LIC_DIV_SLOW; // RULE_17
            end

            unique case (s.tx_state)
                lic_pkg::LIC_TX_IDLE:
                begin
                    if (fif.out_valid)
                    begin
                        next_s.shreg = {1'b0, fif.out_data[7:1]};
                        next_s.bits_left = 3'h7;
                        next_s.tx_state = lic_pkg::LIC_TX_SHIFT;
                    end
                end
                lic_pkg::LIC_TX_SHIFT:
                begin
                    next_s.shreg = {1'b0, s.shreg[7:1]};
                    next_s.bits_left = s.bits_left - 3'h1;
                    if (s.bits_left == 3'h1)
                    begin
                        next_s.tx_state = lic_pkg::LIC_TX_IDLE;
                    end
                end
            endcase

            next_s.cur_mark = new_bit || new_viol;
            if (new_viol)
            begin
                // Same level as the last one, so the far end sees a code violation
                next_s.bit_level = !s.ones_level; // RULE_05
                next_s.zero_run = 2'h0;
            end
            else if (new_bit)
            begin
                next_s.bit_level = s.ones_level; // RULE_03
                next_s.ones_level = !s.ones_level; // RULE_03
                next_s.zero_run = 2'h0;
            end
            else if (s.zero_run != 2'h3)
            begin
                next_s.zero_run = s.zero_run + 2'h1;
            end
        end

        // Trip flag: a new trip in the clear cycle wins
        if (JITTER_TRIP_CLEAR)
        begin
            next_s.trip = 1'b0;
        end
        if (boundary && next_s.div != `LIC_DIV_NORMAL)
        begin
            next_s.trip = 1'b1; // RULE_17
        end

        // Line coder; data is forced low while powered down
        if (!tx_enable)
        begin
            next_s.tx_pos = 1'b0; // RULE_07
            next_s.tx_neg = 1'b0;
        end
        else if (CMI_ENABLE)
        begin
            next_s.tx_neg = 1'b0; // RULE_04
            if (s.cur_mark)
            begin
                next_s.tx_pos = s.bit_level; // RULE_02
            end
            else
            begin
                next_s.tx_pos = !first_half; // RULE_01
            end
        end
        else
        begin
            // Bipolar return-to-zero marks, alternate polarity
            next_s.tx_pos = s.cur_mark && first_half && s.bit_level;
            next_s.tx_neg = s.cur_mark && first_half && !s.bit_level;
        end

        // CMI decoder: falling edges only occur at bit boundaries, so they set phase
        next_s.rx_prev = RX_LINE_POS;
        next_s.rx_valid = 1'b0;
        if (rx_fall)
        begin
            next_s.rx_phase = 4'h1; // RULE_06
        end
        else if (s.rx_phase == `LIC_RX_PERIOD_LAST)
        begin
            next_s.rx_phase = 4'h0;
        end
        else
        begin
            next_s.rx_phase = s.rx_phase + 4'h1;
        end
        if (s.rx_phase == `LIC_RX_SAMPLE_EARLY)
        begin
            next_s.rx_early = RX_LINE_POS;
        end
        if (s.rx_phase == `LIC_RX_SAMPLE_LATE && CMI_ENABLE)
        begin
            // Equal halves decode as one, a mid-bit change as zero
            next_s.rx_data = (s.rx_early == RX_LINE_POS); // RULE_06
            next_s.rx_valid = 1'b1; // RULE_04
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s <= '0;
            s.ctrl_one <= `LIC_RESET_CTRL_ONE;
            s.psa_one <= `LIC_RESET_PSA;
            s.psa_two <= `LIC_RESET_PSA;
            s.div <= `LIC_DIV_NORMAL;
            s.ones_level <= 1'b1;
            s.tx_state <= lic_pkg::LIC_TX_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    always_comb
    begin
        unique case ({E1_MODE, equalizer_gain_limit})
            2'b00: EQ_GAIN_LIMIT = lic_pkg::LIC_EQ_36DB; // RULE_12
            2'b01: EQ_GAIN_LIMIT = lic_pkg::LIC_EQ_15DB; // RULE_12
            2'b10: EQ_GAIN_LIMIT = lic_pkg::LIC_EQ_12DB; // RULE_12
            2'b11: EQ_GAIN_LIMIT = lic_pkg::LIC_EQ_43DB; // RULE_12
        endcase
    end

    assign RD_DATA = s.rd_data;
    // Enables are low while driving; negative line idles in CMI but stays driven
    assign TX_LINE_POS = s.tx_pos;
    assign TX_LINE_NEG = s.tx_neg;
    assign TX_LINE_POS_OE_N = !tx_enable; // RULE_07
    assign TX_LINE_NEG_OE_N = !tx_enable; // RULE_07
    assign RX_DATA = s.rx_data;
    assign RX_VALID = s.rx_valid;
    assign RX_RECOVERED_CLK = !s.rx_phase[3];
    assign JITTER_LIMIT_TRIP = s.trip;
    assign JITTER_ATTEN_ACTIVE = !jitter_atten_disable; // RULE_09
    assign JITTER_ATTEN_TX_SIDE = jitter_atten_side_sel; // RULE_11
    assign LINE_BUILD_OUT = build_out;
    // Legacy codes remain honoured in E1 as high return loss settings
    assign HIGH_RETURN_LOSS = E1_MODE && (build_out == `LIC_LBO_HRL_75
        || build_out == `LIC_LBO_HRL_120); // RULE_14
    assign PULSE_SHAPE_ONE = s.psa_one;
    assign PULSE_SHAPE_TWO = s.psa_two;
endmodule : lic_line_ctrl

/* lic_line_cfg.svh */
// Register offsets, field positions, reset values and counts for the line control block
// What the document asks of this block and of its software
// RULE_01 - CMI zero: low for first half bit, high for second half.
// RULE_02 - CMI one: one constant level held for the whole bit period.
// RULE_03 - Successive CMI ones alternate level, starting high after reset.
// RULE_04 - One enable bit turns CMI on both ways; positive output carries CMI.
// RULE_05 - HDB3/B8ZS style zero substitution may still precede the CMI coder.
// RULE_06 - Positive receive input is unipolar CMI; clock recovered, data aligned.
// RULE_07 - Transmitter on only if power-down bit is one and pin does not override.
// RULE_08 - Line-test select zero ignores pin; one lets high pin force power-down.
// RULE_09 - Control bit 1: zero enables jitter attenuator, one removes it.
// RULE_10 - Control bit 2 selects attenuator depth: 128 bits or 32 bits.
// RULE_11 - Control bit 3 places attenuator in receive path or transmit path.
// RULE_12 - Control bit 4 selects equalizer gain limit, meaning depends on T1/E1.
// RULE_13 - Software uses build-out 000 or 001 for E1 internal termination.
// RULE_14 - Build-out 100 and 101 are legacy, still accepted as high return loss.
// RULE_15 - Software sets T1 AGC pulse-shape values per build-out code.
// RULE_16 - Software sets E1 pulse-shape values; 75 ohm normal uses 20h and 08h.
// RULE_17 - Attenuator divides by 16, else 15 or 17 near limit and latches trip.
`ifndef LIC_LINE_CFG_SVH
`define LIC_LINE_CFG_SVH

`define LIC_ADDR_CTRL_ONE 8'h78
`define LIC_ADDR_PSA_ONE 8'hf1
`define LIC_ADDR_PSA_TWO 8'hf2
`define LIC_RESET_CTRL_ONE 8'h00
`define LIC_RESET_PSA 8'h00

`define LIC_BIT_TX_POWER 0
`define LIC_BIT_JA_DISABLE 1
`define LIC_BIT_JA_DEPTH 2
`define LIC_BIT_JA_SIDE 3
`define LIC_BIT_EQ_LIMIT 4
`define LIC_LBO_LSB 5
`define LIC_LBO_MSB 7
`define LIC_LBO_HRL_75 3'h4
`define LIC_LBO_HRL_120 3'h5

`define LIC_DIV_NORMAL 5'h10
`define LIC_DIV_FAST 5'h0f
`define LIC_DIV_SLOW 5'h11
`define LIC_JA_DEPTH_DEEP 8'h80
`define LIC_JA_DEPTH_SHALLOW 8'h20
`define LIC_JA_TRIP_DEEP 8'h78
`define LIC_JA_TRIP_SHALLOW 8'h1c
`define LIC_JA_LOW_MARK 8'h08

`define LIC_RX_PERIOD_LAST 4'hf
`define LIC_RX_SAMPLE_EARLY 4'h4
`define LIC_RX_SAMPLE_LATE 4'hc

`endif

/* lic_pkg.sv */
// Types shared by the line control block
package lic_pkg;

    typedef enum logic [0:0] {
        LIC_TX_IDLE = 1'b0,
        LIC_TX_SHIFT = 1'b1
    } lic_tx_state_t;

    typedef enum logic [1:0] {
        LIC_EQ_36DB = 2'h0,
        LIC_EQ_15DB = 2'h1,
        LIC_EQ_12DB = 2'h2,
        LIC_EQ_43DB = 2'h3
    } lic_eq_limit_t;

    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] psa_one;
        logic [7:0] psa_two;
        logic [7:0] rd_data;
        lic_tx_state_t tx_state;
        logic [7:0] shreg;
        logic [2:0] bits_left;
        logic [4:0] cnt;
        logic [4:0] div;
        logic cur_mark;
        logic bit_level;
        logic ones_level;
        logic [1:0] zero_run;
        logic tx_pos;
        logic tx_neg;
        logic trip;
        logic rx_prev;
        logic [3:0] rx_phase;
        logic rx_early;
        logic rx_data;
        logic rx_valid;
    } lic_top_state_t;

endpackage : lic_pkg

/* lic_fifo_if.sv */
// Handshake bundle between the line control top and its data FIFO
`timescale 1ns/10ps
interface lic_fifo_if #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;
    logic [$clog2(DEPTH):0] count;

    modport fifo (
        input in_data, in_valid, out_ready,
        output in_ready, out_data, out_valid, count
    );
    modport user (
        output in_data, in_valid, out_ready,
        input in_ready, out_data, out_valid, count
    );
endinterface : lic_fifo_if

/* lic_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module lic_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    lic_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } lic_fifo_state_t;

    lic_fifo_state_t s;
    lic_fifo_state_t next_s;
    logic push;
    logic pop;

    generate
        if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
        begin : g_bad_param
            $error("lic_fifo: depth must be a power of two of at least 2");
        end
    endgenerate

    assign port.in_ready = (s.count != DEPTH[AW:0]);
    assign port.out_valid = (s.count != '0);
    assign port.out_data = s.mem[s.rd_ptr];
    assign port.count = s.count;
    assign push = port.in_valid && port.in_ready;
    assign pop = port.out_valid && port.out_ready;

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr_ptr] = port.in_data;
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_s.count = s.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule : lic_fifo

/* lic_line_ctrl_asserts.sv */
// Concurrent checks on the ports of the line control top
`timescale 1ns/10ps
module lic_line_ctrl_asserts (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] RD_DATA,
    input wire logic CMI_ENABLE,
    input wire logic LINE_TEST_SELECT,
    input wire logic EXTERNAL_POWER_DOWN_PIN,
    input wire logic E1_MODE,
    input wire logic JITTER_TRIP_CLEAR,
    input wire logic TX_LINE_POS,
    input wire logic TX_LINE_POS_OE_N,
    input wire logic TX_LINE_NEG,
    input wire logic TX_LINE_NEG_OE_N,
    input wire logic RX_VALID,
    input wire logic JITTER_LIMIT_TRIP,
    input wire logic JITTER_ATTEN_ACTIVE,
    input wire logic JITTER_ATTEN_TX_SIDE,
    input wire logic [1:0] EQ_GAIN_LIMIT,
    input wire logic [2:0] LINE_BUILD_OUT,
    input wire logic HIGH_RETURN_LOSS
);
    logic [7:0] ctrl;
    logic [4:0] run;
    logic prev;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);
    // Shadow of the control register, and run length of a driven CMI level
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ctrl <= 8'h00;
            run <= 5'h00;
            prev <= 1'b0;
        end
        else
        begin
            prev <= TX_LINE_POS;
            ctrl <= (WR_EN && ADDR == 8'h78) ? WR_DATA : ctrl;
            run <= (TX_LINE_POS_OE_N || !CMI_ENABLE || TX_LINE_POS != prev) ? 5'h00
                : run + {4'h0, run != 5'h1f};
        end
    end
    // Longest legal level: one held 17 cycles after a paced half of 9
    cmi_run_a: assert property (run <= 5'd25)
        else $error("line level held too long");
    pwr_enable_a: assert property (TX_LINE_POS_OE_N == TX_LINE_NEG_OE_N &&
        TX_LINE_POS_OE_N == !(ctrl[0] && !(LINE_TEST_SELECT && EXTERNAL_POWER_DOWN_PIN)))
        else $error("transmit enable wrong");
    rx_quiet_a: assert property (!CMI_ENABLE ##1 !CMI_ENABLE |-> !RX_VALID)
        else $error("decoded bit without CMI");
    neg_idle_a: assert property (CMI_ENABLE [*3] |-> !TX_LINE_NEG)
        else $error("negative line active in CMI");
    ja_enable_a: assert property (JITTER_ATTEN_ACTIVE == !ctrl[1])
        else $error("attenuator enable wrong");
    ja_side_a: assert property (JITTER_ATTEN_TX_SIDE == ctrl[3])
        else $error("attenuator side wrong");
    eq_limit_a: assert property (EQ_GAIN_LIMIT == {E1_MODE, ctrl[4]})
        else $error("gain limit wrong");
    build_out_a: assert property (LINE_BUILD_OUT == ctrl[7:5])
        else $error("build-out wrong");
    hrl_flag_a: assert property (HIGH_RETURN_LOSS == (E1_MODE && ctrl[7:6] == 2'b10))
        else $error("return loss flag wrong");
    rd_back_a: assert property (RD_EN && ADDR == 8'h78 |=> RD_DATA == $past(ctrl))
        else $error("control readback wrong");
    trip_hold_a: assert property (JITTER_LIMIT_TRIP && !JITTER_TRIP_CLEAR |=> JITTER_LIMIT_TRIP)
        else $error("trip flag lost");
endmodule : lic_line_ctrl_asserts

bind lic_line_ctrl lic_line_ctrl_asserts chk (.*);

/* lic_line_partner.sv */
// Optical module model: loops the transmit line back into the receive input
`timescale 1ns/10ps
module lic_line_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_in,
    input wire logic line_oe_n,
    input wire logic slow,
    output logic line_out
);
    logic [7:0] pipe;
    // A released line flips every cycle so a stale level never looks valid
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pipe <= 8'h00;
        end
        else
        begin
            pipe <= {pipe[6:0], line_oe_n ? ~pipe[0] : line_in};
        end
    end
    assign line_out = slow ? pipe[5] : pipe[0];
endmodule : lic_line_partner

/* tb_lic_line_ctrl.sv */
// Self-checking bench for the line control top with an optical loopback
`timescale 1ns/10ps
module tb_lic_line_ctrl;
    logic SYS_CLK, TX_READY, TX_LINE_POS, TX_LINE_NEG, TX_LINE_POS_OE_N, TX_LINE_NEG_OE_N;
    logic RESET_N = 1'b0, WR_EN = 1'b0, RD_EN = 1'b0, CMI_ENABLE = 1'b0, TX_VALID = 1'b0;
    logic LINE_TEST_SELECT = 1'b0, EXTERNAL_POWER_DOWN_PIN = 1'b0, E1_MODE = 1'b0;
    logic ZERO_SUB_EN = 1'b0, JITTER_TRIP_CLEAR = 1'b0, slow = 1'b0, rd_seen = 1'b0;
    logic RX_LINE_POS, RX_DATA, RX_VALID, RX_RECOVERED_CLK, JITTER_LIMIT_TRIP, rc_prev;
    logic JITTER_ATTEN_ACTIVE, JITTER_ATTEN_TX_SIDE, HIGH_RETURN_LOSS;
    logic [7:0] ADDR = 8'h00, WR_DATA = 8'h00, TX_DATA = 8'h00;
    logic [7:0] RD_DATA, PULSE_SHAPE_ONE, PULSE_SHAPE_TWO, got, c, p1, p2;
    logic [1:0] EQ_GAIN_LIMIT;
    logic [2:0] LINE_BUILD_OUT;
    logic [7:0] rd_q[$], tx_q[$];
    logic [7:0] tbl[5] = '{8'hff, 8'h01, 8'h81, 8'h55, 8'hf3};
    int n_errors = 0, comparisons = 0, seed = 44, nbit = 0, acc, ones, edges;
    lic_line_ctrl dut (.*);
    lic_line_partner far_end (.clk(SYS_CLK), .rst_n(RESET_N), .line_in(TX_LINE_POS),
        .line_oe_n(TX_LINE_POS_OE_N), .slow(slow), .line_out(RX_LINE_POS));
    initial
    begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge SYS_CLK);
        WR_EN <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        rd_q.push_back(e);
        @(posedge SYS_CLK);
        RD_EN <= 1'b0;
    endtask : rd
    task automatic tx(input logic [7:0] b);
        @(posedge SYS_CLK);
        TX_DATA <= b;
        TX_VALID <= 1'b1;
        tx_q.push_back(b);
        do @(posedge SYS_CLK); while (TX_READY !== 1'b1);
        TX_VALID <= 1'b0;
    endtask : tx
    // Bytes are odd, so the first decoded one after idle zeros marks bit 0
    always @(posedge SYS_CLK)
    begin
        if (rd_seen)
            check(RD_DATA, rd_q.pop_front());
        rd_seen = RD_EN;
        if (RX_VALID === 1'b1 && (nbit != 0 || (RX_DATA === 1'b1 && tx_q.size() > 0)))
        begin
            got = {RX_DATA, got[7:1]};
            nbit++;
            if (nbit == 8)
            begin
                check(got, tx_q.pop_front());
                nbit = 0;
            end
        end
    end
    initial
    begin
        repeat (30000) @(posedge SYS_CLK);
        n_errors++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        CMI_ENABLE <= 1'b1;
        rd(8'h78, 8'h00);
        rd(8'hf1, 8'h00);
        rd(8'hf2, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            c = $random(seed);
            p1 = (i == 0) ? 8'h78 : 8'hf0 + 8'(i);
            wr(p1, c);
            rd(p1, c);
        end
        wr(8'h79, 8'hff);
        rd(8'h79, 8'h00);
        rd(8'hf2, c);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge SYS_CLK);
            LINE_TEST_SELECT <= i[2];
            EXTERNAL_POWER_DOWN_PIN <= i[1];
            wr(8'h78, {7'h00, i[0]});
            @(negedge SYS_CLK);
            check(TX_LINE_POS_OE_N, !(i[0] && !(i[2] && i[1])));
            check(TX_LINE_NEG_OE_N, !(i[0] && !(i[2] && i[1])));
        end
        for (int i = 0; i < 16; i++)
        begin
            @(posedge SYS_CLK);
            LINE_TEST_SELECT <= 1'b0;
            E1_MODE <= i[3];
            c = {i[2:0], 5'($random(seed)) | 5'h01};
            p1 = i[3] ? ((i[2:0] == 0) ? 8'h20 : 8'h00)
                : ((i[2:0] inside {1, 2, 4}) ? 8'h0a : 8'h00);
            p2 = (i[3] && i[2:0] == 0) ? 8'h08 : 8'h00;
            wr(8'h78, c);
            wr(8'hf1, p1);
            wr(8'hf2, p2);
            @(negedge SYS_CLK);
            check(PULSE_SHAPE_ONE, p1);
            check(PULSE_SHAPE_TWO, p2);
            check(LINE_BUILD_OUT, c[7:5]);
            check(HIGH_RETURN_LOSS, i[3] && c[7:6] == 2'b10);
            check(EQ_GAIN_LIMIT, {i[3], c[4]});
            check({JITTER_ATTEN_ACTIVE, JITTER_ATTEN_TX_SIDE}, {!c[1], c[3]});
        end
        wr(8'h78, 8'h03);
        E1_MODE <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            slow <= k[0];
            repeat (64) @(posedge SYS_CLK);
            foreach (tbl[j])
                tx(tbl[j]);
            tx(8'($random(seed)) | 8'h01);
            while (tx_q.size() > 0) @(posedge SYS_CLK);
        end
        // Third pass turns CMI off: the decoder must then stay silent
        for (int k = 0; k < 3; k++)
        begin
            ZERO_SUB_EN <= (k != 1);
            CMI_ENABLE <= (k != 2);
            repeat (64) @(posedge SYS_CLK);
            ones = 0;
            edges = 0;
            rc_prev = RX_RECOVERED_CLK;
            repeat (640) @(posedge SYS_CLK)
            begin
                ones += (RX_VALID === 1'b1 && RX_DATA === 1'b1);
                edges += (RX_RECOVERED_CLK === 1'b1 && rc_prev === 1'b0);
                rc_prev = RX_RECOVERED_CLK;
            end
            check(ones != 0, k == 0);
            if (k < 2)
                check(8'(edges), 8'd40);
        end
        ZERO_SUB_EN <= 1'b0;
        CMI_ENABLE <= 1'b1;
        // Paced attenuator on the transmit side, filled until refused, then drained
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h78, k[0] ? 8'h09 : 8'h0d);
            TX_VALID <= 1'b1;
            TX_DATA <= 8'h00;
            acc = 0;
            repeat (40) @(posedge SYS_CLK) acc += (TX_READY === 1'b1);
            TX_VALID <= 1'b0;
            check(k[0] ? acc inside {[16:17]} : acc inside {[4:5]}, 1'b1);
            check(JITTER_LIMIT_TRIP, 1'b1);
            repeat (3000) @(posedge SYS_CLK);
            JITTER_TRIP_CLEAR <= 1'b1;
            @(posedge SYS_CLK);
            JITTER_TRIP_CLEAR <= 1'b0;
            @(negedge SYS_CLK);
            check(JITTER_LIMIT_TRIP, 1'b0);
        end
        summarize();
    end
endmodule : tb_lic_line_ctrl
